// [scd_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes: Offsets are byte addresses of the low byte of each register
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

`define SCD_OFF_FLASH_CNT 7'h00
`define SCD_OFF_PIN 7'h32
`define SCD_OFF_MSC 7'h34
`define SCD_OFF_DIO 7'h36
`define SCD_OFF_STATUS 7'h3c
`define SCD_OFF_CMD 7'h3e
`define SCD_OFF_LOT1 7'h52
`define SCD_OFF_LOT2 7'h54
`define SCD_OFF_PART 7'h56
`define SCD_OFF_SERIAL 7'h58

`define SCD_CMD_MASK 16'h3dbf
`define SCD_CMD_RESTORE 13
`define SCD_CMD_SAVE 12
`define SCD_CMD_CAPT 11
`define SCD_CMD_PTR 10
`define SCD_CMD_CLRBUF 8
`define SCD_CMD_SWRST 7
`define SCD_CMD_FTEST 5
`define SCD_CMD_CLRSTAT 4
`define SCD_CMD_FACTORY 3
`define SCD_CMD_SELFTEST 2
`define SCD_CMD_PWRDN 1
`define SCD_CMD_AUTONULL 0

`define SCD_DIO_RESET 6'h0f
`define SCD_DIO_FN1_LSB 2
`define SCD_PIN_LVL_LSB 8
`define SCD_MSC_BIT 8
`define SCD_STAT_SELFTEST 5
`define SCD_STAT_FTEST 6
`define SCD_STAT_ALARM_LSB 8
`define SCD_STAT_MASK 16'h7fff

`define SCD_CLK_PERIOD_NS 10
`define SCD_T_CLRBUF_NS 840000
`define SCD_T_RESTORE_NS 980000
`define SCD_T_RESTORE_CAP_NS 7000000
`define SCD_T_SAVE_NS 339000000
`define SCD_T_SAVE_CAP_NS 509000000
`define SCD_T_PTR_NS 35000
`define SCD_T_SWRST_NS 54000000
`define SCD_T_FTEST_NS 10500000
`define SCD_T_CLRSTAT_NS 35000
`define SCD_T_FACTORY_NS 339000000
`define SCD_T_SELFTEST_NS 33000000
`define SCD_T_AUTONULL_NS 936000000
`define SCD_T_TRIG_MIN_NS 2600
`define SCD_CYC(t) ((t) / `SCD_CLK_PERIOD_NS)
`define SCD_CYC_UP(t) (((t) + `SCD_CLK_PERIOD_NS - 1) / `SCD_CLK_PERIOD_NS)

`endif

// [scd_pkg.sv]
// Purpose: Types shared by the system command and line control block
// Assumes: Nothing beyond the config header
// Notes: Line function codes follow the function field encoding
package scd_pkg;
	typedef enum logic [1:0] {
		SCD_FN_GPIO = 2'b00,
		SCD_FN_ALARM = 2'b01,
		SCD_FN_TRIG = 2'b10,
		SCD_FN_BUSY = 2'b11
	} scd_fn_e;
	typedef enum logic [1:0] {
		SCD_EX_IDLE = 2'b01,
		SCD_EX_RUN = 2'b10
	} scd_exec_e;
endpackage : scd_pkg

// [scd_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Each bit is an independent level
// Notes: Only the second stage is visible outside
`timescale 1ns/100ps
module scd_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			meta <= '0;
			q_o <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule : scd_sync

// [scd_spi_link.sv]
// Purpose: Serial slave front end on the link clock, 16-bit frames
// Assumes: Clock idles high, data sampled on rising, shifted on falling
// Notes: Chip select high clears the frame counters asynchronously
`timescale 1ns/100ps
module scd_spi_link (
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic rst_i,
	input wire logic din_i,
	input wire logic [15:0] rd_word_i,
	output logic dout_o,
	output logic [15:0] frame_word_o,
	output logic frame_tgl_o
);
	logic [14:0] shift;
	logic [3:0] in_cnt;
	logic [3:0] out_idx;

	always_ff @(posedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			in_cnt <= 4'h0;
		else
			in_cnt <= in_cnt + 4'h1;
	end

	always_ff @(posedge sclk_i)
		shift <= {shift[13:0], din_i};

	// Word held until the next full frame, so the other domain reads it calmly
	always_ff @(posedge sclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			frame_word_o <= 16'h0000;
			frame_tgl_o <= 1'b0;
		end
		else if (!cs_n_i && in_cnt == 4'hf)
		begin
			frame_word_o <= {shift, din_i};
			frame_tgl_o <= ~frame_tgl_o;
		end
	end

	// Read word is quasi-static: only updated between frames
	always_ff @(negedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
			out_idx <= 4'h0;
		else
			out_idx <= out_idx + 4'h1;
	end

	always_ff @(negedge sclk_i)
		dout_o <= rd_word_i[~out_idx];
endmodule : scd_spi_link

// [scd_top.sv]
// Purpose: System command launcher and two-line digital I/O control
// Assumes: Host is serial master and pauses traffic while commands run
// Notes: Function engines outside see cmd_run_o and report back
// How it works
// R1 - A command bit written one runs, then clears itself when done.
// R2 - Bit 8 clears capture buffers, running 0.84 ms.
// R3 - Bit 13 restores from flash, 0.98 ms or 7.0 ms with capture data.
// R4 - Bit 12 saves to flash, 339 ms or 509 ms with capture data.
// R5 - Bit 10 zeroes read pointer in 0.035 ms; bit 11 toggles capture mode.
// R6 - Bit 5 runs flash checksum test, 10.5 ms, result to status.
// R7 - Bit 3 restores factory register defaults and clears buffers, 339 ms.
// R8 - Bit 2 runs self-test 33 ms, outcome into status bit 5.
// R9 - Host makes no serial transfers while a command executes.
// R10 - Busy output asserts during capture, register writes and command execution.
// R11 - Line function register resets to 0x000f: line one active-high busy, line two gpio.
// R12 - Trigger input fires on falling edge after high pulse of 2.6 us.
// R13 - Alarm output goes active when threshold alarm flags are set.
// R14 - Alarm stays active until status clear command, then goes inactive.
// R15 - Bits 5:4 and 3:2 select line functions: gpio, alarm, trigger, busy.
// R16 - Bits 1 and 0 set line polarity, unused in general-purpose mode.
// R17 - Pin control bits 1:0 direction, bits 9:8 output level.
// R18 - Input gpio lines read back their pin state in pin control.
// R19 - Bits 7, 4, 1, 0: software reset, status clear, power-down, autonull.
// R20 - Reserved bits ignore writes and read back zero.
`timescale 1ns/100ps
`include "scd_cfg.svh"
module scd_top #(
	parameter logic [31:0] N_CLRBUF = `SCD_CYC(`SCD_T_CLRBUF_NS),
	parameter logic [31:0] N_RESTORE = `SCD_CYC(`SCD_T_RESTORE_NS),
	parameter logic [31:0] N_RESTORE_CAP = `SCD_CYC(`SCD_T_RESTORE_CAP_NS),
	parameter logic [31:0] N_SAVE = `SCD_CYC(`SCD_T_SAVE_NS),
	parameter logic [31:0] N_SAVE_CAP = `SCD_CYC(`SCD_T_SAVE_CAP_NS),
	parameter logic [31:0] N_SWRST = `SCD_CYC(`SCD_T_SWRST_NS),
	parameter logic [31:0] N_FTEST = `SCD_CYC(`SCD_T_FTEST_NS),
	parameter logic [31:0] N_FACTORY = `SCD_CYC(`SCD_T_FACTORY_NS),
	parameter logic [31:0] N_SELFTEST = `SCD_CYC(`SCD_T_SELFTEST_NS),
	parameter logic [31:0] N_AUTONULL = `SCD_CYC(`SCD_T_AUTONULL_NS),
	parameter logic [15:0] LOT_FIRST = 16'h1111, // Arbitrary value
	parameter logic [15:0] LOT_SECOND = 16'h2222, // Arbitrary value
	parameter logic [15:0] PART_CODE = 16'h0a5a, // Arbitrary value
	parameter logic [15:0] SERIAL = 16'h0001, // Arbitrary value
	parameter logic [15:0] FLASH_COUNT_RESET = 16'h0000
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	output logic dout_o,
	input wire logic io_line_one_i,
	output logic io_line_one_o,
	output logic io_line_one_oe_o,
	input wire logic io_line_two_i,
	output logic io_line_two_o,
	output logic io_line_two_oe_o,
	input wire logic capture_active_i,
	input wire logic capture_backup_i,
	input wire logic [15:0] status_set_i,
	input wire logic selftest_fail_i,
	input wire logic flash_sum_fail_i,
	output logic [15:0] cmd_run_o,
	output logic capture_run_o,
	output logic power_down_o,
	output logic manual_selftest_o,
	output logic capture_trigger_o
);
	import scd_pkg::*;

	localparam logic [31:0] N_PTR = `SCD_CYC(`SCD_T_PTR_NS);
	localparam logic [31:0] N_CLRSTAT = `SCD_CYC(`SCD_T_CLRSTAT_NS);
	localparam logic [8:0] N_TRIG_MIN = 9'(`SCD_CYC_UP(`SCD_T_TRIG_MIN_NS));

	logic [15:0] frame_word;
	logic frame_tgl;
	logic [2:0] sync_q;
	logic tgl_seen;
	logic [15:0] rd_word;
	logic [15:0] cmd_pend;
	logic [3:0] cur;
	logic [31:0] cnt;
	scd_exec_e state;
	logic [5:0] io_cfg;
	logic [1:0] pin_dir;
	logic [1:0] pin_lvl;
	logic msc;
	logic [15:0] status;
	logic [15:0] flash_count;
	logic wr_busy;
	logic [1:0] trg_pulse;

	scd_spi_link u_link (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.rst_i(reset_i),
		.din_i(din_i),
		.rd_word_i(rd_word),
		.dout_o(dout_o),
		.frame_word_o(frame_word),
		.frame_tgl_o(frame_tgl)
	);

	scd_sync #(.W(3)) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.d_i({frame_tgl, io_line_two_i, io_line_one_i}),
		.q_o(sync_q)
	);

	// Frame decode: bit 15 write flag, 14:8 byte address, 7:0 data
	wire take = sync_q[2] ^ tgl_seen;
	wire is_wr = frame_word[15];
	wire [6:0] waddr = {frame_word[14:9], 1'b0};
	wire hi_byte = frame_word[8];
	wire [7:0] wdata = frame_word[7:0];
	wire wr_go = take && is_wr;
	wire cmd_wr = wr_go && waddr == `SCD_OFF_CMD;
	wire dio_wr = wr_go && waddr == `SCD_OFF_DIO && !hi_byte;
	wire pin_wr = wr_go && waddr == `SCD_OFF_PIN;
	wire msc_wr = wr_go && waddr == `SCD_OFF_MSC && hi_byte;
	wire [15:0] cmd_set = (hi_byte ? {wdata, 8'h00} : {8'h00, wdata}) & `SCD_CMD_MASK; // R20
	wire [1:0] pin_now = sync_q[1:0];

	// Lowest pending bit runs first
	function automatic logic [3:0] first_set(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 15; k >= 0; k--)
			if (v[k])
				r = 4'(k);
		return r;
	endfunction : first_set

	function automatic logic [31:0] run_len(input logic [3:0] idx, input logic bk);
		logic [31:0] r;
		r = 32'h0000_0001;
		unique case (idx)
			4'(`SCD_CMD_RESTORE): r = bk ? N_RESTORE_CAP : N_RESTORE; // R3
			4'(`SCD_CMD_SAVE): r = bk ? N_SAVE_CAP : N_SAVE; // R4
			4'(`SCD_CMD_PTR): r = N_PTR; // R5
			4'(`SCD_CMD_CLRBUF): r = N_CLRBUF; // R2
			4'(`SCD_CMD_SWRST): r = N_SWRST; // R19
			4'(`SCD_CMD_FTEST): r = N_FTEST; // R6
			4'(`SCD_CMD_CLRSTAT): r = N_CLRSTAT; // R19
			4'(`SCD_CMD_FACTORY): r = N_FACTORY; // R7
			4'(`SCD_CMD_SELFTEST): r = N_SELFTEST; // R8
			4'(`SCD_CMD_AUTONULL): r = N_AUTONULL; // R19
			default: r = 32'h0000_0001;
		endcase
		return r;
	endfunction : run_len

	wire [3:0] start_idx = first_set(cmd_pend);
	wire start = state == SCD_EX_IDLE && cmd_pend != 16'h0000;
	wire finish = state == SCD_EX_RUN && cnt == 32'h0000_0000;
	wire [15:0] done_mask = finish ? 16'(1) << cur : 16'h0000;
	wire restore_regs = done_mask[`SCD_CMD_FACTORY] || done_mask[`SCD_CMD_SWRST]; // R7
	wire clr_stat = done_mask[`SCD_CMD_CLRSTAT]; // R14
	wire [15:0] stat_set = status_set_i
		| (done_mask[`SCD_CMD_SELFTEST] ? 16'(selftest_fail_i) << `SCD_STAT_SELFTEST : 16'h0)
		| (done_mask[`SCD_CMD_FTEST] ? 16'(flash_sum_fail_i) << `SCD_STAT_FTEST : 16'h0);
	// An event in the clearing cycle survives
	wire [15:0] next_status = ((clr_stat ? 16'h0000 : status) | stat_set) & `SCD_STAT_MASK;
	wire alarm = |status[`SCD_STAT_ALARM_LSB +: 4]; // R13
	wire busy = capture_active_i || wr_busy || cmd_pend != 16'h0000; // R10

	wire [15:0] pin_rd = {6'h00, pin_dir & pin_lvl | ~pin_dir & pin_now, 6'h00, pin_dir}; // R18
	wire [6:0] raddr = waddr;
	wire [15:0] rd_val =
		raddr == `SCD_OFF_FLASH_CNT ? flash_count :
		raddr == `SCD_OFF_PIN ? pin_rd :
		raddr == `SCD_OFF_MSC ? 16'(msc) << `SCD_MSC_BIT :
		raddr == `SCD_OFF_DIO ? {10'h000, io_cfg} :
		raddr == `SCD_OFF_STATUS ? status :
		raddr == `SCD_OFF_CMD ? cmd_pend :
		raddr == `SCD_OFF_LOT1 ? LOT_FIRST :
		raddr == `SCD_OFF_LOT2 ? LOT_SECOND :
		raddr == `SCD_OFF_PART ? PART_CODE :
		raddr == `SCD_OFF_SERIAL ? SERIAL : 16'h0000;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			tgl_seen <= 1'b0;
			rd_word <= 16'h0000;
			wr_busy <= 1'b0;
		end
		else
		begin
			tgl_seen <= sync_q[2];
			wr_busy <= wr_go; // R10
			if (take && !is_wr)
				rd_word <= rd_val;
		end
	end

	// Command executor
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			state <= SCD_EX_IDLE;
			cur <= 4'h0;
			cnt <= 32'h0000_0000;
			cmd_run_o <= 16'h0000;
		end
		else
		begin
			unique case (state)
				SCD_EX_IDLE:
					if (start)
					begin
						state <= SCD_EX_RUN;
						cur <= start_idx;
						cnt <= run_len(start_idx, capture_backup_i) - 32'h0000_0001;
						cmd_run_o <= 16'(1) << start_idx;
					end
				SCD_EX_RUN:
					if (finish)
					begin
						state <= SCD_EX_IDLE;
						cmd_run_o <= 16'h0000;
					end
					else
						cnt <= cnt - 32'h0000_0001;
			endcase
		end
	end

	// Pending bits; a fresh write wins over the self-clear
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			cmd_pend <= 16'h0000;
		else
			cmd_pend <= (cmd_pend & ~done_mask) | (cmd_wr ? cmd_set : 16'h0000); // R1
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			status <= 16'h0000;
			flash_count <= FLASH_COUNT_RESET;
			capture_run_o <= 1'b0;
			power_down_o <= 1'b0;
		end
		else
		begin
			status <= next_status;
			if (done_mask[`SCD_CMD_SAVE])
				flash_count <= flash_count + 16'h0001; // R4
			if (done_mask[`SCD_CMD_CAPT])
				capture_run_o <= ~capture_run_o; // R5
			if (done_mask[`SCD_CMD_PWRDN])
				power_down_o <= 1'b1; // R19
			else if (done_mask[`SCD_CMD_SWRST])
				power_down_o <= 1'b0;
		end
	end

	// Configuration; restore beats a racing write
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || restore_regs)
		begin
			io_cfg <= `SCD_DIO_RESET; // R11
			pin_dir <= 2'b00;
			pin_lvl <= 2'b00;
			msc <= 1'b0;
		end
		else
		begin
			if (dio_wr)
				io_cfg <= wdata[5:0]; // R15
			if (pin_wr && !hi_byte)
				pin_dir <= wdata[1:0]; // R17
			if (pin_wr && hi_byte)
				pin_lvl <= wdata[1:0]; // R17
			if (msc_wr)
				msc <= wdata[0];
		end
	end
	assign manual_selftest_o = msc;

	logic [1:0] line_out;
	logic [1:0] line_oe;

	for (genvar i = 0; i < 2; i++)
	begin : g_line
		localparam int FN_LSB = `SCD_DIO_FN1_LSB + 2 * i;
		scd_fn_e fn;
		logic pol;
		logic act_in;
		logic high_seen;
		logic [8:0] high_cnt;
		assign fn = scd_fn_e'(io_cfg[FN_LSB +: 2]); // R15
		assign pol = io_cfg[i]; // R16
		assign act_in = pol ? pin_now[i] : ~pin_now[i];

		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i)
			begin
				line_out[i] <= 1'b0;
				line_oe[i] <= 1'b0;
			end
			else
			begin
				unique case (fn)
					SCD_FN_GPIO:
					begin
						line_out[i] <= pin_lvl[i]; // R17
						line_oe[i] <= pin_dir[i];
					end
					SCD_FN_ALARM:
					begin
						line_out[i] <= ~(alarm ^ pol); // R14
						line_oe[i] <= 1'b1;
					end
					SCD_FN_TRIG:
					begin
						line_out[i] <= 1'b0;
						line_oe[i] <= 1'b0;
					end
					SCD_FN_BUSY:
					begin
						line_out[i] <= ~(busy ^ pol); // R10
						line_oe[i] <= 1'b1;
					end
				endcase
			end
		end

		// Trigger: rising then falling edge, high for the least width
		always_ff @(posedge sys_clk_i)
		begin
			if (reset_i || fn != SCD_FN_TRIG)
			begin
				high_seen <= 1'b0;
				high_cnt <= 9'h000;
				trg_pulse[i] <= 1'b0;
			end
			else
			begin
				high_seen <= act_in;
				if (!act_in)
					high_cnt <= 9'h000;
				else if (high_cnt != N_TRIG_MIN)
					high_cnt <= high_cnt + 9'h001;
				trg_pulse[i] <= high_seen && !act_in && high_cnt == N_TRIG_MIN; // R12
			end
		end
	end

	assign io_line_one_o = line_out[0];
	assign io_line_one_oe_o = line_oe[0];
	assign io_line_two_o = line_out[1];
	assign io_line_two_oe_o = line_oe[1];
	assign capture_trigger_o = |trg_pulse;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	property p_self_clear;
		finish && !cmd_wr |=> !cmd_pend[$past(cur)] && state == SCD_EX_IDLE;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("command bit stayed set"); // R1
	property p_clrbuf_len;
		start && start_idx == 4'(`SCD_CMD_CLRBUF) |=> cnt == N_CLRBUF - 32'h0000_0001;
	endproperty
	a_clrbuf_len: assert property (p_clrbuf_len) else $error("clear buffer time wrong"); // R2
	property p_restore_len;
		start && start_idx == 4'(`SCD_CMD_RESTORE) && capture_backup_i
			|=> cnt == N_RESTORE_CAP - 32'h0000_0001;
	endproperty
	a_restore_len: assert property (p_restore_len) else $error("restore time wrong"); // R3
	property p_save_count;
		finish && cur == 4'(`SCD_CMD_SAVE) |=> flash_count == $past(flash_count) + 16'h0001;
	endproperty
	a_save_count: assert property (p_save_count) else $error("flash count not bumped"); // R4
	property p_ptr_run;
		start && start_idx == 4'(`SCD_CMD_PTR) |=> cmd_run_o[`SCD_CMD_PTR] [*3];
	endproperty
	a_ptr_run: assert property (p_ptr_run) else $error("pointer reset not running"); // R5
	property p_selftest;
		finish && cur == 4'(`SCD_CMD_SELFTEST) && selftest_fail_i |=> status[`SCD_STAT_SELFTEST];
	endproperty
	a_selftest: assert property (p_selftest) else $error("self-test result lost"); // R8
	property p_busy_line;
		io_cfg[3:2] == 2'b11 && io_cfg[0] && cmd_pend != 16'h0000 |=> io_line_one_o;
	endproperty
	a_busy_line: assert property (p_busy_line) else $error("busy line not active"); // R10
	property p_reset_cfg;
		$past(reset_i) |-> io_cfg == `SCD_DIO_RESET && io_line_two_oe_o == 1'b0;
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config"); // R11
	property p_trig_width;
		$rose(trg_pulse[1]) |-> $past(g_line[1].high_cnt) == N_TRIG_MIN;
	endproperty
	a_trig_width: assert property (p_trig_width) else $error("short trigger accepted"); // R12
	property p_alarm_clear;
		finish && cur == 4'(`SCD_CMD_CLRSTAT) && status_set_i == 16'h0 && io_cfg[5:4] == 2'b01
			&& io_cfg[1] |=> ##1 !io_line_two_o;
	endproperty
	a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not released"); // R14
endmodule : scd_top

// [scd_host_model.sv]
// Purpose: Serial master standing in for the host processor
// Assumes: Mode 3 framing, 16-bit words, link clock period 15 ns
// Notes: Link clock stands high between frames; data line flips when idle
`timescale 1ns/100ps
module scd_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic dout_i
);
	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// One whole frame, MSB first; reply sampled on each rising edge
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		int i;
		cs_n_o = 1'b0;
		for (i = 15; i >= 0; i--)
		begin
			#7.5 sclk_o = 1'b0;
			din_o = tx[i];
			#7.5 sclk_o = 1'b1;
			rx[i] = dout_i;
		end
		#7.5 cs_n_o = 1'b1;
		// Released line must not keep showing the last bit
		din_o = ~din_o;
		#60;
	endtask : xfer
endmodule : scd_host_model

// [system_command_and_dio_control_test.sv]
// Purpose: Self-checking bench for the command launcher and line control
// Assumes: Short command counts; host model drives the serial link
// Notes: Status clear and pointer reset keep their full 3500-cycle run
`timescale 1ns/100ps
`include "scd_cfg.svh"
module system_command_and_dio_control_test;
	localparam int T_SHORT = `SCD_CYC(`SCD_T_PTR_NS);
	localparam logic [15:0] PART = 16'h0b0b; // Arbitrary value
	localparam logic [31:0] C_CLRBUF = 32'd20, C_RESTORE = 32'd24, C_RESTORE_CAP = 32'd40;
	localparam logic [31:0] C_SAVE = 32'd50, C_SAVE_CAP = 32'd70, C_SWRST = 32'd30;
	localparam logic [31:0] C_FTEST = 32'd26, C_FACTORY = 32'd44, C_SELFTEST = 32'd28;
	localparam logic [31:0] C_AUTONULL = 32'd60;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sclk, cs_n, din, dout;
	logic line1_i = 1'b0;
	logic line2_i = 1'b0;
	logic l1_o, l1_oe, l2_o, l2_oe;
	logic capture_active_i = 1'b0;
	logic capture_backup_i = 1'b0;
	logic [15:0] status_set_i = 16'h0000;
	logic selftest_fail_i = 1'b0;
	logic flash_sum_fail_i = 1'b0;
	logic [15:0] cmd_run_o;
	logic capture_run_o, power_down_o, manual_selftest_o, capture_trigger_o;
	logic clr = 1'b0;
	logic busy_watch = 1'b0;
	int sel = 0;
	int run_cnt = 0;
	int busy_miss = 0;
	int trig_cnt = 0;
	int n_errors = 0;
	int total_checks = 0;
	logic [15:0] v;
	int i;
	int cbit[13] = '{4, 8, 13, 13, 12, 12, 5, 3, 2, 10, 0, 11, 1};
	int clen[13] = '{T_SHORT, C_CLRBUF, C_RESTORE, C_RESTORE_CAP, C_SAVE, C_SAVE_CAP,
		C_FTEST, C_FACTORY, C_SELFTEST, T_SHORT, C_AUTONULL, 1, 1};
	logic cbk[13] = '{0, 0, 0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0};

	always #5 sys_clk_i = ~sys_clk_i;

	scd_host_model host (
		.sclk_o(sclk),
		.cs_n_o(cs_n),
		.din_o(din),
		.dout_i(dout)
	);

	scd_top #(
		.N_CLRBUF(C_CLRBUF), .N_RESTORE(C_RESTORE), .N_RESTORE_CAP(C_RESTORE_CAP),
		.N_SAVE(C_SAVE), .N_SAVE_CAP(C_SAVE_CAP), .N_SWRST(C_SWRST), .N_FTEST(C_FTEST),
		.N_FACTORY(C_FACTORY), .N_SELFTEST(C_SELFTEST), .N_AUTONULL(C_AUTONULL),
		.PART_CODE(PART)
	) dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.din_i(din), .dout_o(dout), .io_line_one_i(line1_i), .io_line_one_o(l1_o),
		.io_line_one_oe_o(l1_oe), .io_line_two_i(line2_i), .io_line_two_o(l2_o),
		.io_line_two_oe_o(l2_oe), .capture_active_i(capture_active_i),
		.capture_backup_i(capture_backup_i), .status_set_i(status_set_i),
		.selftest_fail_i(selftest_fail_i), .flash_sum_fail_i(flash_sum_fail_i),
		.cmd_run_o(cmd_run_o), .capture_run_o(capture_run_o), .power_down_o(power_down_o),
		.manual_selftest_o(manual_selftest_o), .capture_trigger_o(capture_trigger_o)
	);

	always @(posedge sys_clk_i)
	begin
		if (clr)
			run_cnt <= 0;
		else if (cmd_run_o[sel] === 1'b1)
			run_cnt <= run_cnt + 1;
		if (clr)
			trig_cnt <= 0;
		else if (capture_trigger_o === 1'b1)
			trig_cnt <= trig_cnt + 1;
		if (busy_watch && cmd_run_o !== 16'h0000 && l1_o !== 1'b1)
			busy_miss <= busy_miss + 1;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : tick

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] rx;
		host.xfer({1'b1, a, d}, rx);
		tick(3);
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [15:0] q);
		logic [15:0] rx;
		host.xfer({1'b0, a, 8'h00}, rx);
		host.xfer(16'h0000, q);
	endtask : rd

	task automatic run_cmd(input int b, input int n);
		int k;
		sel = b;
		@(posedge sys_clk_i);
		clr <= 1'b1;
		@(posedge sys_clk_i);
		clr <= 1'b0;
		if (b >= 8)
			wr(`SCD_OFF_CMD + 7'h01, 8'(1 << (b - 8)));
		else
			wr(`SCD_OFF_CMD, 8'(1 << b));
		k = 0;
		// No serial traffic until the command has finished
		while (k < 8000 && !(run_cnt > 0 && cmd_run_o === 16'h0000))
		begin
			tick(1);
			k++;
		end
		check("command run length", run_cnt[15:0], n[15:0]);
		// Let the lines settle on the idle state after the command
		tick(2);
	endtask : run_cmd

	task automatic lines(input logic [3:0] exp);
		check("line drive", {12'h000, l1_oe, l1_o, l2_oe, l2_o}, {12'h000, exp});
	endtask : lines

	initial
	begin
		#400us;
		n_errors++;
		print_verdict();
	end

	initial
	begin
		tick(10);
		reset_i <= 1'b0;
		tick(3);
		lines(4'b1000);
		rd(`SCD_OFF_DIO, v);
		check("io config", v, 16'h000f);
		rd(`SCD_OFF_PIN, v);
		check("pin control", v, 16'h0000);
		rd(`SCD_OFF_PART, v);
		check("part code", v, PART);
		rd(7'h40, v);
		check("unmapped", v, 16'h0000);
		capture_active_i <= 1'b1;
		tick(5);
		lines(4'b1100);
		capture_active_i <= 1'b0;
		selftest_fail_i <= 1'b1;
		flash_sum_fail_i <= 1'b1;
		busy_watch <= 1'b1;
		for (i = 0; i < 13; i++)
		begin
			capture_backup_i <= cbk[i];
			run_cmd(cbit[i], clen[i]);
			rd(`SCD_OFF_CMD, v);
			check("command readback", v, 16'h0000);
		end
		rd(`SCD_OFF_STATUS, v);
		check("status", v, 16'h0060);
		rd(`SCD_OFF_FLASH_CNT, v);
		check("flash count", v, 16'h0002);
		check("capture run", {15'h0, capture_run_o}, 16'h0001);
		check("power down", {15'h0, power_down_o}, 16'h0001);
		run_cmd(7, C_SWRST);
		check("power down", {15'h0, power_down_o}, 16'h0000);
		check("busy misses", busy_miss[15:0], 16'h0000);
		busy_watch <= 1'b0;
		wr(`SCD_OFF_DIO, 8'hff);
		wr(`SCD_OFF_DIO + 7'h01, 8'hff);
		rd(`SCD_OFF_DIO, v);
		check("io config", v, 16'h003f);
		wr(`SCD_OFF_PIN, 8'hff);
		wr(`SCD_OFF_PIN + 7'h01, 8'hff);
		rd(`SCD_OFF_PIN, v);
		check("pin control", v, 16'h0303);
		wr(`SCD_OFF_CMD, 8'h40);
		check("reserved command", cmd_run_o, 16'h0000);
		wr(`SCD_OFF_MSC + 7'h01, 8'hff);
		rd(`SCD_OFF_MSC, v);
		check("self-test control", v, 16'h0100);
		check("manual self-test", {15'h0, manual_selftest_o}, 16'h0001);
		wr(`SCD_OFF_DIO, 8'h00);
		wr(`SCD_OFF_PIN, 8'h01);
		wr(`SCD_OFF_PIN + 7'h01, 8'h01);
		line1_i <= 1'b1;
		line2_i <= 1'b1;
		tick(5);
		lines(4'b1100);
		rd(`SCD_OFF_PIN, v);
		check("pin readback", v, 16'h0301);
		line1_i <= 1'b0;
		line2_i <= 1'b0;
		tick(5);
		rd(`SCD_OFF_PIN, v);
		check("pin readback", v, 16'h0101);
		wr(`SCD_OFF_DIO, 8'h1f);
		lines(4'b1010);
		status_set_i <= 16'h0200;
		tick(1);
		status_set_i <= 16'h0000;
		tick(3);
		lines(4'b1011);
		run_cmd(4, T_SHORT);
		lines(4'b1010);
		wr(`SCD_OFF_DIO, 8'h1d);
		lines(4'b1011);
		wr(`SCD_OFF_DIO, 8'h2f);
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
		// First pulse is held high under the minimum width and must not fire; the second is long enough to fire
		line2_i <= 1'b1;
		tick(200);
		line2_i <= 1'b0;
		tick(10);
		check("short trigger", trig_cnt[15:0], 16'h0000);
		line2_i <= 1'b1;
		tick(300);
		line2_i <= 1'b0;
		tick(10);
		check("trigger count", trig_cnt[15:0], 16'h0001);
		check("trigger line enable", {15'h0, l2_oe}, 16'h0000);
		print_verdict();
	end
endmodule : system_command_and_dio_control_test
